// [psu_seq_pkg.sv]
package psu_seq_pkg;

  // Timebase
  localparam int unsigned CLK_KHZ = 20000;
  localparam real         ROUND_EPS = 0.000001;

  // Sequencer times in milliseconds
  localparam real INRUSH_MIN_DELAY_MS = 81.5;
  localparam real FAULT_TIME_MS       = 1.65;
  localparam real IND_DELAY_MS        = 24.0;
  localparam real BIAS_TIMEOUT_MS     = 50.0;
  localparam real SRC_OFF_DELAY_MS    = 24.0;
  localparam real KA_TICK_MS          = 0.001;

  // Least times, rounded up to whole cycles
  localparam int unsigned INRUSH_MIN_CYC =
    int'($ceil(INRUSH_MIN_DELAY_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned FAULT_CYC =
    int'($ceil(FAULT_TIME_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned IND_DELAY_CYC =
    int'($ceil(IND_DELAY_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned BIAS_TIMEOUT_CYC =
    int'($ceil(BIAS_TIMEOUT_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned SRC_OFF_CYC =
    int'($ceil(SRC_OFF_DELAY_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned KA_TICK_CYC =
    int'($ceil(KA_TICK_MS * CLK_KHZ - ROUND_EPS));
  localparam int unsigned TIMER_W = 21;

  // Keepalive period in timebase ticks and duty cycles in per mille
  localparam int unsigned KA_PERIOD_TICKS = 1000;
  localparam int unsigned KA_W            = 16;
  localparam int unsigned PM_SCALE        = 1000;
  localparam int unsigned DUTY_T12_PM     = 260;
  localparam int unsigned DUTY_SHORT_PM   = 125;
  localparam int unsigned DUTY_RES_PM     = 81;
  localparam int unsigned DUTY_OPEN_PM    = 54;

  // Current limits in milliamps per variant
  localparam int unsigned ILIM_W = 12;
  localparam logic [ILIM_W-1:0] ILIM_INRUSH_STD_MA = 12'h0C8;
  localparam logic [ILIM_W-1:0] ILIM_INRUSH_HI_MA  = 12'h14F;
  localparam logic [ILIM_W-1:0] ILIM_OPER_STD_MA   = 12'h708;
  localparam logic [ILIM_W-1:0] ILIM_OPER_HI_MA    = 12'h898;
  localparam logic [ILIM_W-1:0] ILIM_OFF_MA        = 12'h000;

  // Classification
  localparam int unsigned CLASS_W = 3;
  localparam logic [CLASS_W-1:0] CLASS_CNT_RST = 3'h0;
  localparam logic [CLASS_W-1:0] CLASS_CNT_MAX = 3'h5;

  // Duty select pin strapping
  typedef enum logic [1:0] {
    DUTY_SHORT = 2'h0,
    DUTY_RES   = 2'h1,
    DUTY_OPEN  = 2'h2
  } duty_sel_t;

  // Main phase
  typedef enum logic [3:0] {
    PH_OFF     = 4'h1,
    PH_INRUSH  = 4'h2,
    PH_RUN     = 4'h4,
    PH_ADAPTER = 4'h8
  } phase_t;

  // Bias supply startup
  typedef enum logic [3:0] {
    BS_IDLE   = 4'h1,
    BS_START  = 4'h2,
    BS_CLOSED = 4'h4,
    BS_RUN    = 4'h8
  } bias_t;

endpackage

// [interval_timer.sv]
`timescale 1ns/1ps
module interval_timer #(
  parameter int unsigned CNT_W = 21,
  parameter int unsigned COUNT = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      done_o
);

  logic [CNT_W-1:0] cnt;

  // Counts while run is held, clears as soon as it drops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt <= '0;
    end
    else if (!run_i)
    begin
      cnt <= '0;
    end
    else if (cnt != CNT_W'(COUNT))
    begin
      cnt <= cnt + CNT_W'(1);
    end
  end

  // Level: run has been held for COUNT cycles
  assign done_o = (cnt == CNT_W'(COUNT));

endmodule

// [powered_device_startup_sequencer.sv]
`timescale 1ns/1ps
module powered_device_startup_sequencer #(
  parameter bit          HIGH_POWER_VARIANT = 1'b1,
  parameter int unsigned INRUSH_MIN_CYC     = psu_seq_pkg::INRUSH_MIN_CYC,
  parameter int unsigned FAULT_CYC          = psu_seq_pkg::FAULT_CYC,
  parameter int unsigned IND_DELAY_CYC      = psu_seq_pkg::IND_DELAY_CYC,
  parameter int unsigned BIAS_TIMEOUT_CYC   = psu_seq_pkg::BIAS_TIMEOUT_CYC,
  parameter int unsigned SRC_OFF_CYC        = psu_seq_pkg::SRC_OFF_CYC,
  parameter int unsigned KA_TICK_CYC        = psu_seq_pkg::KA_TICK_CYC,
  parameter int unsigned KA_PERIOD_TICKS    = psu_seq_pkg::KA_PERIOD_TICKS
) (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       VDD_ABOVE_UVLO_I,
  input  wire logic       VDD_ABOVE_IND_CUTOFF_I,
  input  wire logic       THERMAL_SHUTDOWN_I,
  input  wire logic       INRUSH_CURRENT_DROP_I,
  input  wire logic       LOAD_RETURN_FAULT_I,
  input  wire logic       BIAS_FEEDBACK_IN_HIGH_I,
  input  wire logic       BIAS_SUPPLY_OUT_BELOW_HI_I,
  input  wire logic       BIAS_SUPPLY_OUT_BELOW_LO_I,
  input  wire logic       BIAS_THRESHOLD_SELECT_I,
  input  wire logic       KEEPALIVE_LOW_CURRENT_I,
  input  wire logic [1:0] KEEPALIVE_DUTY_SELECT_I,
  input  wire logic       ADAPTER_DETECT_I,
  input  wire logic       CLASS_EVENT_I,
  input  wire logic       CLASS_SOURCE_TYPE34_I,
  output logic            PASS_SWITCH_ON_O,
  output logic [11:0]     CURRENT_LIMIT_MA_O,
  output logic            INRUSH_DONE_OUT_O,
  output logic            INRUSH_DONE_OUT_OE_O,
  output logic            POWER_LEVEL_HIGH_IND_O,
  output logic            POWER_LEVEL_HIGH_IND_OE_O,
  output logic            POWER_LEVEL_LOW_IND_O,
  output logic            POWER_LEVEL_LOW_IND_OE_O,
  output logic            ENHANCED_SOURCE_IND_N_O,
  output logic            ENHANCED_SOURCE_IND_N_OE_O,
  output logic            BIAS_STARTUP_SOURCE_ON_O,
  output logic            BIAS_SWITCH_ON_O,
  output logic            KEEPALIVE_PULSE_OUT_O
);

  localparam int unsigned TW = psu_seq_pkg::TIMER_W;
  localparam int unsigned KW = psu_seq_pkg::KA_W;
  localparam int unsigned PM = psu_seq_pkg::PM_SCALE;
  localparam logic [KW-1:0] KA_LAST = KW'(KA_PERIOD_TICKS - 1);
  localparam logic [KW-1:0] ON_T12 = KW'(KA_PERIOD_TICKS * psu_seq_pkg::DUTY_T12_PM / PM);
  localparam logic [KW-1:0] ON_SHORT = KW'(KA_PERIOD_TICKS * psu_seq_pkg::DUTY_SHORT_PM / PM);
  localparam logic [KW-1:0] ON_RES = KW'(KA_PERIOD_TICKS * psu_seq_pkg::DUTY_RES_PM / PM);
  localparam logic [KW-1:0] ON_OPEN = KW'(KA_PERIOD_TICKS * psu_seq_pkg::DUTY_OPEN_PM / PM);
  localparam logic [7:0] TICK_LAST = 8'(KA_TICK_CYC - 1);

  psu_seq_pkg::phase_t state;
  psu_seq_pkg::phase_t next_state;
  psu_seq_pkg::bias_t  bias;
  psu_seq_pkg::bias_t  next_bias;

  logic                               waive;
  logic                               drop_seen;
  logic                               min_done;
  logic                               fault_done;
  logic                               bias_tmo_done;
  logic                               src_off_done;
  logic                               ind_dly_done;
  logic                               ind_en;
  logic                               ind_cutoff;
  logic                               bias_uv;
  logic                               bias_active;
  logic                               class_open;
  logic [psu_seq_pkg::CLASS_W-1:0]    class_cnt;
  logic                               type34;
  logic                               code_high;
  logic                               code_low;
  logic [7:0]                         ka_div;
  logic                               ka_tick;
  logic [KW-1:0]                      ka_phase;
  logic [KW-1:0]                      ka_on;
  logic                               ka_run;
  logic                               inrush_done;

  // Inrush may end only after the drop and the minimum delay or a waiver
  assign inrush_done = drop_seen && (min_done || waive);
  assign bias_active = (state == psu_seq_pkg::PH_RUN) || (state == psu_seq_pkg::PH_ADAPTER);
  assign bias_uv     = BIAS_THRESHOLD_SELECT_I ? BIAS_SUPPLY_OUT_BELOW_LO_I
                                               : BIAS_SUPPLY_OUT_BELOW_HI_I;
  assign ind_cutoff  = THERMAL_SHUTDOWN_I || bias_uv || !VDD_ABOVE_IND_CUTOFF_I;

  // Timers on the system clock
  interval_timer #(.CNT_W(TW), .COUNT(INRUSH_MIN_CYC)) u_min (
    .clk_i(CLK_I), .rst_n_i(RST_N_I),
    .run_i(state == psu_seq_pkg::PH_INRUSH), .done_o(min_done));
  interval_timer #(.CNT_W(TW), .COUNT(FAULT_CYC)) u_fault (
    .clk_i(CLK_I), .rst_n_i(RST_N_I),
    .run_i(state == psu_seq_pkg::PH_RUN && LOAD_RETURN_FAULT_I), .done_o(fault_done));
  interval_timer #(.CNT_W(TW), .COUNT(BIAS_TIMEOUT_CYC)) u_btmo (
    .clk_i(CLK_I), .rst_n_i(RST_N_I),
    .run_i(bias == psu_seq_pkg::BS_START && !BIAS_FEEDBACK_IN_HIGH_I),
    .done_o(bias_tmo_done));
  interval_timer #(.CNT_W(TW), .COUNT(SRC_OFF_CYC)) u_srcoff (
    .clk_i(CLK_I), .rst_n_i(RST_N_I),
    .run_i(bias == psu_seq_pkg::BS_CLOSED), .done_o(src_off_done));
  interval_timer #(.CNT_W(TW), .COUNT(IND_DELAY_CYC)) u_ind (
    .clk_i(CLK_I), .rst_n_i(RST_N_I),
    .run_i(state == psu_seq_pkg::PH_RUN && BIAS_FEEDBACK_IN_HIGH_I && !ind_cutoff),
    .done_o(ind_dly_done));

  // Phase selection; adapter has priority, then supply and thermal
  always_comb
  begin
    next_state = state;
    if (ADAPTER_DETECT_I)
    begin
      next_state = psu_seq_pkg::PH_ADAPTER;
    end
    else if (!VDD_ABOVE_UVLO_I || THERMAL_SHUTDOWN_I || state == psu_seq_pkg::PH_ADAPTER)
    begin
      next_state = psu_seq_pkg::PH_OFF;
    end
    else
    begin
      case (state)
        psu_seq_pkg::PH_OFF:    next_state = psu_seq_pkg::PH_INRUSH;
        psu_seq_pkg::PH_INRUSH: if (inrush_done) next_state = psu_seq_pkg::PH_RUN;
        psu_seq_pkg::PH_RUN:    if (fault_done) next_state = psu_seq_pkg::PH_INRUSH;
        default:                next_state = psu_seq_pkg::PH_OFF;
      endcase
    end
  end

  // Phase register
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state <= psu_seq_pkg::PH_OFF;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Waiver of the minimum delay after a load return fault
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      waive <= 1'b0;
    end
    else if (state == psu_seq_pkg::PH_RUN && next_state == psu_seq_pkg::PH_INRUSH)
    begin
      waive <= 1'b1;
    end
    else if (state != psu_seq_pkg::PH_INRUSH)
    begin
      waive <= 1'b0;
    end
  end

  // Current drop seen during inrush switches the limit to operating
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      drop_seen <= 1'b0;
    end
    else if (state != psu_seq_pkg::PH_INRUSH)
    begin
      drop_seen <= 1'b0;
    end
    else if (INRUSH_CURRENT_DROP_I)
    begin
      drop_seen <= 1'b1;
    end
  end

  // Pass switch, current limit and power-good
  assign PASS_SWITCH_ON_O = (state == psu_seq_pkg::PH_INRUSH) ||
                            (state == psu_seq_pkg::PH_RUN);
  always_comb
  begin
    if (!PASS_SWITCH_ON_O)
    begin
      CURRENT_LIMIT_MA_O = psu_seq_pkg::ILIM_OFF_MA;
    end
    else if (state == psu_seq_pkg::PH_RUN || drop_seen)
    begin
      CURRENT_LIMIT_MA_O = HIGH_POWER_VARIANT ? psu_seq_pkg::ILIM_OPER_HI_MA
                                              : psu_seq_pkg::ILIM_OPER_STD_MA;
    end
    else
    begin
      CURRENT_LIMIT_MA_O = HIGH_POWER_VARIANT ? psu_seq_pkg::ILIM_INRUSH_HI_MA
                                              : psu_seq_pkg::ILIM_INRUSH_STD_MA;
    end
  end
  assign INRUSH_DONE_OUT_O    = 1'b0;
  assign INRUSH_DONE_OUT_OE_O = (state == psu_seq_pkg::PH_INRUSH);

  // Class cycles counted before power-up, frozen afterwards
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      class_cnt  <= psu_seq_pkg::CLASS_CNT_RST;
      type34     <= 1'b0;
      class_open <= 1'b0;
    end
    else if (state != psu_seq_pkg::PH_OFF)
    begin
      class_open <= 1'b0;
    end
    else if (CLASS_EVENT_I)
    begin
      class_open <= 1'b1;
      type34     <= class_open ? (type34 || CLASS_SOURCE_TYPE34_I) : CLASS_SOURCE_TYPE34_I;
      if (!class_open)
      begin
        class_cnt <= 3'h1;
      end
      else if (class_cnt != psu_seq_pkg::CLASS_CNT_MAX)
      begin
        class_cnt <= class_cnt + 3'h1;
      end
    end
  end

  // Level code from cycles received, demotion falls out of the count
  always_comb
  begin
    case (class_cnt)
      3'h2, 3'h3: {code_high, code_low} = 2'h2;
      3'h4:       {code_high, code_low} = 2'h1;
      3'h5:       {code_high, code_low} = 2'h0;
      default:    {code_high, code_low} = 2'h3;
    endcase
  end

  // Indicator enable, dropped on cutoff and re-armed after startup
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ind_en <= 1'b0;
    end
    else if (ind_cutoff || state != psu_seq_pkg::PH_RUN)
    begin
      ind_en <= 1'b0;
    end
    else if (ind_dly_done)
    begin
      ind_en <= 1'b1;
    end
  end

  // Indicator pins from flip-flops
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      POWER_LEVEL_HIGH_IND_O     <= 1'b1;
      POWER_LEVEL_HIGH_IND_OE_O  <= 1'b0;
      POWER_LEVEL_LOW_IND_O      <= 1'b1;
      POWER_LEVEL_LOW_IND_OE_O   <= 1'b0;
      ENHANCED_SOURCE_IND_N_O    <= 1'b1;
      ENHANCED_SOURCE_IND_N_OE_O <= 1'b0;
    end
    else if (state == psu_seq_pkg::PH_ADAPTER)
    begin
      POWER_LEVEL_HIGH_IND_O     <= 1'b0;
      POWER_LEVEL_HIGH_IND_OE_O  <= 1'b1;
      POWER_LEVEL_LOW_IND_OE_O   <= 1'b0;
      ENHANCED_SOURCE_IND_N_OE_O <= 1'b0;
    end
    else
    begin
      POWER_LEVEL_HIGH_IND_O     <= code_high;
      POWER_LEVEL_HIGH_IND_OE_O  <= ind_en;
      POWER_LEVEL_LOW_IND_O      <= code_low;
      POWER_LEVEL_LOW_IND_OE_O   <= ind_en;
      ENHANCED_SOURCE_IND_N_O    <= !type34;
      ENHANCED_SOURCE_IND_N_OE_O <= ind_en;
    end
  end

  // Bias supply startup sequence
  always_comb
  begin
    next_bias = bias;
    if (!bias_active)
    begin
      next_bias = psu_seq_pkg::BS_IDLE;
    end
    else
    begin
      case (bias)
        psu_seq_pkg::BS_IDLE:
          next_bias = psu_seq_pkg::BS_START;
        psu_seq_pkg::BS_START:
          if (BIAS_FEEDBACK_IN_HIGH_I || bias_tmo_done) next_bias = psu_seq_pkg::BS_CLOSED;
        psu_seq_pkg::BS_CLOSED:
          if (bias_uv) next_bias = psu_seq_pkg::BS_START;
          else if (src_off_done) next_bias = psu_seq_pkg::BS_RUN;
        psu_seq_pkg::BS_RUN:
          if (bias_uv) next_bias = psu_seq_pkg::BS_START;
        default:
          next_bias = psu_seq_pkg::BS_IDLE;
      endcase
    end
  end

  // Bias state register
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      bias <= psu_seq_pkg::BS_IDLE;
    end
    else
    begin
      bias <= next_bias;
    end
  end

  // Bias outputs
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      BIAS_STARTUP_SOURCE_ON_O <= 1'b0;
      BIAS_SWITCH_ON_O         <= 1'b0;
    end
    else
    begin
      BIAS_STARTUP_SOURCE_ON_O <= (next_bias == psu_seq_pkg::BS_START) ||
                                  (next_bias == psu_seq_pkg::BS_CLOSED);
      BIAS_SWITCH_ON_O         <= (next_bias == psu_seq_pkg::BS_CLOSED) ||
                                  (next_bias == psu_seq_pkg::BS_RUN);
    end
  end

  // Keepalive timebase: one-cycle tick from a divider
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ka_div <= 8'h00;
    end
    else
    begin
      ka_div <= ka_tick ? 8'h00 : ka_div + 8'h01;
    end
  end
  assign ka_tick = (ka_div == TICK_LAST);

  // Duty cycle: fixed for type 1-2, strap-selected for type 3-4
  always_comb
  begin
    if (!type34)
    begin
      ka_on = ON_T12;
    end
    else if (KEEPALIVE_DUTY_SELECT_I == psu_seq_pkg::DUTY_SHORT)
    begin
      ka_on = ON_SHORT;
    end
    else if (KEEPALIVE_DUTY_SELECT_I == psu_seq_pkg::DUTY_RES)
    begin
      ka_on = ON_RES;
    end
    else
    begin
      ka_on = ON_OPEN;
    end
  end
  assign ka_run = KEEPALIVE_LOW_CURRENT_I && bias_active;

  // Keepalive period counter and pulse
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ka_phase              <= '0;
      KEEPALIVE_PULSE_OUT_O <= 1'b0;
    end
    else if (!ka_run)
    begin
      ka_phase              <= '0;
      KEEPALIVE_PULSE_OUT_O <= 1'b0;
    end
    else
    begin
      if (ka_tick)
      begin
        ka_phase <= (ka_phase == KA_LAST) ? '0 : ka_phase + KW'(1);
      end
      KEEPALIVE_PULSE_OUT_O <= (ka_phase < ka_on);
    end
  end

  // Checks
  a_inrush_start: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_OFF && VDD_ABOVE_UVLO_I && !THERMAL_SHUTDOWN_I && !ADAPTER_DETECT_I
    |=> PASS_SWITCH_ON_O && INRUSH_DONE_OUT_OE_O) else $error("inrush did not start");
  a_limit_switch: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_INRUSH && INRUSH_CURRENT_DROP_I && next_state == state
    |=> CURRENT_LIMIT_MA_O > 12'h400) else $error("limit not raised after drop");
  a_pg_release: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $fell(INRUSH_DONE_OUT_OE_O) && state == psu_seq_pkg::PH_RUN
    |-> $past(drop_seen) && ($past(min_done) || $past(waive))) else $error("early inrush end");
  a_fault_restart: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_RUN && fault_done && next_state == psu_seq_pkg::PH_INRUSH
    |=> state == psu_seq_pkg::PH_INRUSH && waive
    ##1 (state != psu_seq_pkg::PH_INRUSH || waive)) else $error("no waiver");
  a_ind_level: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ind_en && state == psu_seq_pkg::PH_RUN && class_cnt == 3'h4
    |=> !POWER_LEVEL_HIGH_IND_O && POWER_LEVEL_LOW_IND_O && POWER_LEVEL_LOW_IND_OE_O)
    else $error("level code wrong");
  a_ind_type: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ind_en && state == psu_seq_pkg::PH_RUN |=> ENHANCED_SOURCE_IND_N_O == !type34)
    else $error("type indicator wrong");
  a_ind_cutoff: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_RUN && ind_cutoff ##1 state == psu_seq_pkg::PH_RUN
    |=> !POWER_LEVEL_LOW_IND_OE_O && !ENHANCED_SOURCE_IND_N_OE_O) else $error("no cutoff");
  a_bias_close: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    bias == psu_seq_pkg::BS_START && BIAS_FEEDBACK_IN_HIGH_I && bias_active
    |=> BIAS_SWITCH_ON_O && BIAS_STARTUP_SOURCE_ON_O) else $error("bias switch not closed");
  a_bias_uv: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    bias == psu_seq_pkg::BS_RUN && bias_uv && bias_active
    |=> BIAS_STARTUP_SOURCE_ON_O && !BIAS_SWITCH_ON_O) else $error("bias restart missing");
  a_ka_stop: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !KEEPALIVE_LOW_CURRENT_I |=> !KEEPALIVE_PULSE_OUT_O) else $error("keepalive not stopped");
  a_adapter_mode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    ADAPTER_DETECT_I [*2] |=> !PASS_SWITCH_ON_O && POWER_LEVEL_HIGH_IND_OE_O
    && !POWER_LEVEL_HIGH_IND_O && !INRUSH_DONE_OUT_OE_O) else $error("adapter override wrong");

  c_inrush_end: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_INRUSH ##1 state == psu_seq_pkg::PH_RUN);
  c_fault_restart: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    state == psu_seq_pkg::PH_RUN ##1 state == psu_seq_pkg::PH_INRUSH && waive);
  c_ind_on: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(POWER_LEVEL_HIGH_IND_OE_O) && state == psu_seq_pkg::PH_RUN);
  c_ka_pulse: cover property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(KEEPALIVE_PULSE_OUT_O));

endmodule

// [pse_model.sv]
`timescale 1ns/1ps
module pse_model (
  input  wire logic clk_i,
  output logic      class_event_o,
  output logic      source_type34_o,
  output logic      vdd_ok_o
);
  // Cable unpowered and no class cycle at start
  initial
  begin
    class_event_o   = 1'b0;
    source_type34_o = 1'b1;
    vdd_ok_o        = 1'b0;
  end

  // Port shut down by the source
  task off();
    vdd_ok_o <= 1'b0;
  endtask

  // Class cycles with gaps, then operating voltage applied
  task classify(input int n, input logic t34);
    repeat (n)
    begin
      @(posedge clk_i);
      class_event_o   <= 1'b1;
      source_type34_o <= t34;
      @(posedge clk_i);
      class_event_o   <= 1'b0;
      source_type34_o <= ~t34; // Type line is not valid between cycles
      @(posedge clk_i);
    end
    @(posedge clk_i);
    vdd_ok_o <= 1'b1;
  endtask
endmodule

// [test_powered_device_startup_sequencer.sv]
`timescale 1ns/1ps
module test_powered_device_startup_sequencer;
  `define CHK(n, e, g) begin #1; total_checks++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s expected %0h seen %0h", n, e, g); end end
  localparam int KA_TICK = 2;
  localparam int KA_PER  = 1000;
  int   fails, total_checks, cycles;
  logic CLK_I, RST_N_I = 1'b0, VDD_ABOVE_IND_CUTOFF_I = 1'b1, THERMAL_SHUTDOWN_I = 1'b0;
  logic INRUSH_CURRENT_DROP_I = 1'b0, LOAD_RETURN_FAULT_I = 1'b0, BIAS_FEEDBACK_IN_HIGH_I = 1'b0;
  logic BIAS_SUPPLY_OUT_BELOW_HI_I = 1'b0, BIAS_SUPPLY_OUT_BELOW_LO_I = 1'b0;
  logic BIAS_THRESHOLD_SELECT_I = 1'b1, KEEPALIVE_LOW_CURRENT_I = 1'b0, ADAPTER_DETECT_I = 1'b0;
  logic [1:0]  KEEPALIVE_DUTY_SELECT_I = 2'h0;
  logic        VDD_ABOVE_UVLO_I, CLASS_EVENT_I, CLASS_SOURCE_TYPE34_I;
  logic        PASS_SWITCH_ON_O, INRUSH_DONE_OUT_O, INRUSH_DONE_OUT_OE_O, KEEPALIVE_PULSE_OUT_O;
  logic        POWER_LEVEL_HIGH_IND_O, POWER_LEVEL_HIGH_IND_OE_O, POWER_LEVEL_LOW_IND_O;
  logic        POWER_LEVEL_LOW_IND_OE_O, ENHANCED_SOURCE_IND_N_O, ENHANCED_SOURCE_IND_N_OE_O;
  logic        BIAS_STARTUP_SOURCE_ON_O, BIAS_SWITCH_ON_O;
  logic [11:0] CURRENT_LIMIT_MA_O;
  logic        hi, lo, t34;

  // Source side of the cable
  pse_model pse (.clk_i(CLK_I), .class_event_o(CLASS_EVENT_I),
    .source_type34_o(CLASS_SOURCE_TYPE34_I), .vdd_ok_o(VDD_ABOVE_UVLO_I));

  // Sequencer with shortened delays
  powered_device_startup_sequencer #(.INRUSH_MIN_CYC(50), .FAULT_CYC(10), .IND_DELAY_CYC(20),
    .BIAS_TIMEOUT_CYC(30), .SRC_OFF_CYC(20), .KA_TICK_CYC(KA_TICK), .KA_PERIOD_TICKS(KA_PER))
    DUT (.*);

  // Clock generation and run limit
  initial
  begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask

  // Indicator enables and code
  task ind(input logic oe);
    `CHK("hi_oe", oe, POWER_LEVEL_HIGH_IND_OE_O)
    `CHK("lo_oe", oe, POWER_LEVEL_LOW_IND_OE_O)
    `CHK("es_oe", oe, ENHANCED_SOURCE_IND_N_OE_O)
    if (oe)
    begin
      `CHK("hi", hi, POWER_LEVEL_HIGH_IND_O)
      `CHK("lo", lo, POWER_LEVEL_LOW_IND_O)
      `CHK("es", ~t34, ENHANCED_SOURCE_IND_N_O)
    end
  endtask

  // Reset, classify, power up, run through inrush and bias startup
  task powerup(input int n, input logic t);
    t34 = t;
    hi = n < 4;
    lo = (n < 2) || (n == 4);
    @(posedge CLK_I);
    RST_N_I <= 1'b0;
    INRUSH_CURRENT_DROP_I <= 1'b0;
    BIAS_FEEDBACK_IN_HIGH_I <= 1'b0;
    pse.off();
    cyc(12);
    RST_N_I <= 1'b1;
    pse.classify(n, t);
    cyc(3);
    `CHK("pass", 1'b1, PASS_SWITCH_ON_O)
    `CHK("limit", psu_seq_pkg::ILIM_INRUSH_HI_MA, CURRENT_LIMIT_MA_O)
    `CHK("done_oe", 1'b1, INRUSH_DONE_OUT_OE_O)
    cyc(1);
    INRUSH_CURRENT_DROP_I <= 1'b1;
    cyc(3);
    `CHK("limit", psu_seq_pkg::ILIM_OPER_HI_MA, CURRENT_LIMIT_MA_O)
    cyc(30);
    `CHK("done_oe", 1'b1, INRUSH_DONE_OUT_OE_O)
    cyc(20);
    BIAS_FEEDBACK_IN_HIGH_I <= 1'b1;
    `CHK("done_oe", 1'b0, INRUSH_DONE_OUT_OE_O)
    `CHK("done", 1'b0, INRUSH_DONE_OUT_O)
    `CHK("src", 1'b1, BIAS_STARTUP_SOURCE_ON_O)
    `CHK("sw", 1'b0, BIAS_SWITCH_ON_O)
    cyc(3);
    `CHK("sw", 1'b1, BIAS_SWITCH_ON_O)
    ind(1'b0);
    cyc(22);
    `CHK("src", 1'b0, BIAS_STARTUP_SOURCE_ON_O)
    ind(1'b1);
    $display("test powerup %0d cycles type34 %0d done", n, t);
  endtask

  // One keepalive period counted, then current above the keepalive level
  task ka(input logic [1:0] sel, input int pm);
    int n;
    n = 0;
    @(posedge CLK_I);
    KEEPALIVE_DUTY_SELECT_I <= sel;
    KEEPALIVE_LOW_CURRENT_I <= 1'b1;
    repeat (KA_PER * KA_TICK)
    begin
      @(posedge CLK_I);
      #1;
      if (KEEPALIVE_PULSE_OUT_O === 1'b1) n++;
    end
    @(posedge CLK_I);
    KEEPALIVE_LOW_CURRENT_I <= 1'b0;
    cyc(2);
    `CHK("ka_off", 1'b0, KEEPALIVE_PULSE_OUT_O)
    `CHK("ka_on", pm * KA_PER / psu_seq_pkg::PM_SCALE * KA_TICK, n)
    $display("test keepalive select %0d done", sel);
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      powerup(i + 1, i > 1);
      if (i == 1) ka(2'h2, psu_seq_pkg::DUTY_T12_PM);
    end
    ka(2'h0, psu_seq_pkg::DUTY_SHORT_PM);
    ka(2'h1, psu_seq_pkg::DUTY_RES_PM);
    ka(2'h2, psu_seq_pkg::DUTY_OPEN_PM);
    @(posedge CLK_I);
    LOAD_RETURN_FAULT_I <= 1'b1;
    INRUSH_CURRENT_DROP_I <= 1'b0;
    cyc(14);
    LOAD_RETURN_FAULT_I <= 1'b0;
    INRUSH_CURRENT_DROP_I <= 1'b1;
    `CHK("done_oe", 1'b1, INRUSH_DONE_OUT_OE_O)
    cyc(6);
    `CHK("done_oe", 1'b0, INRUSH_DONE_OUT_OE_O)
    cyc(17);
    ind(1'b0);
    cyc(23);
    ind(1'b1);
    THERMAL_SHUTDOWN_I <= 1'b1;
    cyc(4);
    THERMAL_SHUTDOWN_I <= 1'b0;
    `CHK("pass", 1'b0, PASS_SWITCH_ON_O)
    `CHK("limit", psu_seq_pkg::ILIM_OFF_MA, CURRENT_LIMIT_MA_O)
    ind(1'b0);
    cyc(90);
    `CHK("pass", 1'b1, PASS_SWITCH_ON_O)
    ind(1'b1);
    VDD_ABOVE_IND_CUTOFF_I <= 1'b0;
    cyc(4);
    VDD_ABOVE_IND_CUTOFF_I <= 1'b1;
    ind(1'b0);
    cyc(30);
    BIAS_SUPPLY_OUT_BELOW_HI_I <= 1'b1;
    cyc(4);
    BIAS_SUPPLY_OUT_BELOW_LO_I <= 1'b1;
    BIAS_FEEDBACK_IN_HIGH_I <= 1'b0;
    `CHK("sw", 1'b1, BIAS_SWITCH_ON_O)
    cyc(4);
    BIAS_SUPPLY_OUT_BELOW_HI_I <= 1'b0;
    BIAS_SUPPLY_OUT_BELOW_LO_I <= 1'b0;
    `CHK("sw", 1'b0, BIAS_SWITCH_ON_O)
    `CHK("src", 1'b1, BIAS_STARTUP_SOURCE_ON_O)
    ind(1'b0);
    cyc(34);
    `CHK("sw", 1'b1, BIAS_SWITCH_ON_O)
    BIAS_THRESHOLD_SELECT_I <= 1'b0;
    BIAS_SUPPLY_OUT_BELOW_HI_I <= 1'b1;
    cyc(2);
    `CHK("sw", 1'b0, BIAS_SWITCH_ON_O)
    BIAS_SUPPLY_OUT_BELOW_HI_I <= 1'b0;
    ADAPTER_DETECT_I <= 1'b1;
    cyc(4);
    `CHK("pass", 1'b0, PASS_SWITCH_ON_O)
    `CHK("done_oe", 1'b0, INRUSH_DONE_OUT_OE_O)
    `CHK("hi_oe", 1'b1, POWER_LEVEL_HIGH_IND_OE_O)
    `CHK("hi", 1'b0, POWER_LEVEL_HIGH_IND_O)
    `CHK("lo_oe", 1'b0, POWER_LEVEL_LOW_IND_OE_O)
    `CHK("es_oe", 1'b0, ENHANCED_SOURCE_IND_N_OE_O)
    $display("test faults and adapter done");
    tally_and_finish();
  end
endmodule
